/* core/lcmfp_pkg.sv */
// Purpose: Shared constants for the multi-function port selector
// Assumes: Eight channels, five ports per channel, 4-bit selection codes
// Notes: Register index = {channel, offset}; byte address = 4 * index
package lcmfp_pkg;
  // ----------------------------------------
  // Geometry
  // ----------------------------------------
  localparam int NCH = 8; // Channels
  localparam int NPORT = 5; // Ports per channel
  localparam int SEL_W = 4; // Selection field width
  localparam int ADDR_W = 18; // Byte address width
  localparam logic [7:0] CH_MAX = 8'h07; // Highest channel number
  // Port positions inside a channel
  localparam int P_RXA = 0;
  localparam int P_RXB = 1;
  localparam int P_RXC = 2;
  localparam int P_TXA = 3;
  localparam int P_TXB = 4;
  // ----------------------------------------
  // Register offsets (index form)
  // ----------------------------------------
  localparam logic [7:0] OFF_TERM_CTL = 8'h36; // Holds termination bit
  localparam logic [7:0] OFF_TRI_CTL = 8'h40; // Holds receive tristate bit
  localparam logic [7:0] OFF_CFG_ONE = 8'h80;
  localparam logic [7:0] OFF_CFG_TWO = 8'h81;
  localparam logic [7:0] OFF_CFG_THREE = 8'h82;
  localparam logic [7:0] OFF_CFG_FIVE = 8'h84;
  localparam logic [7:0] OFF_READBACK = 8'hab;
  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int RXSEL_LSB = 0; // Receive field in cfg one/two/three
  localparam int TXSEL_LSB = 4; // Transmit field in cfg one/two
  localparam int RCLK_EN_BIT = 0; // Clock output enable in cfg five
  localparam int TERM_BIT = 0; // Termination bit in term ctl
  localparam int TRI_BIT = 0; // Tristate bit in tri ctl
  localparam logic [3:0] SEL_RST = 4'h0;
  localparam logic [3:0] RXC_SEL_RST = 4'hf;
  localparam logic RCLK_EN_RST = 1'b0;
  localparam logic BIT_RST = 1'b0;
  // ----------------------------------------
  // Selection codes
  // ----------------------------------------
  localparam logic [3:0] C_TX_CLK_IN = 4'h3; // Tx clock input
  localparam logic [3:0] C_TX_CLK_OUT = 4'h7; // Tx clock output
  localparam logic [3:0] C_TERM = 4'h8; // Rx termination / tx tristate high
  localparam logic [3:0] C_GEN_IN = 4'h9; // General input
  localparam logic [3:0] C_HIGH = 4'ha; // Fixed high output
  localparam logic [3:0] C_LOW = 4'hb; // Fixed low output
  localparam logic [3:0] C_LOS = 4'hc; // Loss of signal out (rx only)
  localparam logic [3:0] C_TRI_IN = 4'hd; // Rx tristate in / tx neg rail in
  localparam logic [3:0] C_NEG = 4'he; // Rx neg rail out / tx tristate low
  localparam logic [3:0] C_RCLK = 4'hf; // Recovered clock out (rx only)
endpackage

/* core/lcmfp_chan.sv */
// Purpose: Per-channel routing of five multi-function ports
// Assumes: Pin levels arrive already synchronised and filtered
// Notes: All outputs registered; one cycle from cause to pin
`timescale 1ns/1ps
module lcmfp_chan (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] sel_rxa,
  input wire logic [3:0] sel_rxb,
  input wire logic [3:0] sel_rxc,
  input wire logic [3:0] sel_txa,
  input wire logic [3:0] sel_txb,
  input wire logic rclk_en,
  input wire logic term_bit,
  input wire logic tri_bit,
  input wire logic [4:0] lvl,
  input wire logic rclk,
  input wire logic los,
  input wire logic neg,
  input wire logic txclk,
  output logic [4:0] pin_out,
  output logic [4:0] pin_oe_n,
  output logic term,
  output logic rx_tri,
  output logic tx_tri,
  output logic tx_clk_in,
  output logic tx_neg_in
);
  // ----------------------------------------
  // Decode
  // ----------------------------------------
  logic [3:0] sel [lcmfp_pkg::NPORT]; // Field per port
  logic term_c, rxtri_c, txtri_c, txclk_c, tneg_c;
  logic [4:0] out_c, oen_c;

  // Gather fields so the loops can index them
  always_comb begin
    sel[lcmfp_pkg::P_RXA] = sel_rxa;
    sel[lcmfp_pkg::P_RXB] = sel_rxb;
    sel[lcmfp_pkg::P_RXC] = sel_rxc;
    sel[lcmfp_pkg::P_TXA] = sel_txa;
    sel[lcmfp_pkg::P_TXB] = sel_txb;
  end

  // Input functions: several ports on one function are OR'd, harmless
  always_comb begin
    term_c = term_bit;
    rxtri_c = tri_bit;
    txtri_c = 1'b0;
    txclk_c = 1'b0;
    tneg_c = 1'b0;
    for (int p = 0; p < lcmfp_pkg::NPORT; p++) begin
      if (p <= lcmfp_pkg::P_RXC) begin
        if (sel[p] == lcmfp_pkg::C_TERM) term_c = term_c | lvl[p];
        if (sel[p] == lcmfp_pkg::C_TRI_IN) rxtri_c = rxtri_c | lvl[p];
      end else begin
        if (sel[p] == lcmfp_pkg::C_TX_CLK_IN) txclk_c = txclk_c | lvl[p];
        if (sel[p] == lcmfp_pkg::C_TERM) txtri_c = txtri_c | lvl[p];
        if (sel[p] == lcmfp_pkg::C_NEG) txtri_c = txtri_c | ~lvl[p];
        if (sel[p] == lcmfp_pkg::C_TRI_IN) tneg_c = tneg_c | lvl[p];
      end
    end
  end

  // Output functions; anything else leaves the pin passive
  always_comb begin
    out_c = '1;
    oen_c = '1;
    for (int p = 0; p < lcmfp_pkg::NPORT; p++) begin
      case (sel[p])
        lcmfp_pkg::C_HIGH: begin
          out_c[p] = 1'b1;
          oen_c[p] = 1'b0;
        end
        lcmfp_pkg::C_LOW: begin
          out_c[p] = 1'b0;
          oen_c[p] = 1'b0;
        end
        lcmfp_pkg::C_LOS: begin
          out_c[p] = los;
          oen_c[p] = (p > lcmfp_pkg::P_RXC);
        end
        lcmfp_pkg::C_NEG: begin
          out_c[p] = neg;
          oen_c[p] = (p > lcmfp_pkg::P_RXC);
        end
        lcmfp_pkg::C_RCLK: begin
          // Undriven pin floats to the board pull-up
          out_c[p] = rclk;
          oen_c[p] = (p > lcmfp_pkg::P_RXC) | ~rclk_en | rxtri_c;
        end
        lcmfp_pkg::C_TX_CLK_OUT: begin
          out_c[p] = txclk;
          oen_c[p] = (p <= lcmfp_pkg::P_RXC);
        end
        default: begin
          out_c[p] = 1'b1;
          oen_c[p] = 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Registered outputs
  // ----------------------------------------
  // Pins: reset leaves every pin passive
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_out <= '1;
      pin_oe_n <= '1;
    end else begin
      pin_out <= out_c;
      pin_oe_n <= oen_c;
    end
  end

  // Internal function lines
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      term <= 1'b0;
      rx_tri <= 1'b0;
      tx_tri <= 1'b0;
      tx_clk_in <= 1'b0;
      tx_neg_in <= 1'b0;
    end else begin
      term <= term_c;
      rx_tri <= rxtri_c;
      tx_tri <= txtri_c;
      tx_clk_in <= txclk_c;
      tx_neg_in <= tneg_c;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  gpo_high_a: assert property (sel_rxa == lcmfp_pkg::C_HIGH |=> pin_out[0] && !pin_oe_n[0])
    else $error("fixed high not driven");
  gpo_low_a: assert property (sel_txa == lcmfp_pkg::C_LOW |=> !pin_out[3] && !pin_oe_n[3])
    else $error("fixed low not driven");
  los_out_a: assert property (sel_rxa == lcmfp_pkg::C_LOS |=> pin_out[0] == $past(los))
    else $error("loss of signal not routed");
  rclk_gate_a: assert property (sel_rxc == lcmfp_pkg::C_RCLK && !rclk_en |=> pin_oe_n[2])
    else $error("clock driven while disabled");
  tx_reserved_a: assert property (sel_txa == lcmfp_pkg::C_LOS |=> pin_oe_n[3])
    else $error("reserved code drives pin");
  tx_tri_low_a: assert property (sel_txa == lcmfp_pkg::C_NEG && !lvl[3] |=> tx_tri)
    else $error("low tristate input ignored");
  term_or_a: assert property (term_bit |=> term)
    else $error("termination bit not OR'd");
  txclk_out_a: assert property (sel_txa == lcmfp_pkg::C_TX_CLK_OUT |=>
      pin_out[3] == $past(txclk))
    else $error("tx clock not output");
  rx_tri_a: assert property (tri_bit && sel_rxc == lcmfp_pkg::C_RCLK |=>
      rx_tri && pin_oe_n[2])
    else $error("rx tristate not applied");
endmodule

/* core/lcmfp_top.sv */
// Purpose: APB register front end and pin conditioning for port selection
// Assumes: Single clock, zero-wait APB, channel number in index bits 15:8
// Notes: Pin inputs pass three flops; level changes when stages 2 and 3 agree
// Notes: Idle pins read high; the sync stages start at that level
`timescale 1ns/1ps
module lcmfp_top #(
  parameter int NCH = lcmfp_pkg::NCH
) (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [lcmfp_pkg::ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [NCH*lcmfp_pkg::NPORT-1:0] PORT_IN,
  output logic [NCH*lcmfp_pkg::NPORT-1:0] PORT_OUT,
  output logic [NCH*lcmfp_pkg::NPORT-1:0] PORT_OE_N,
  input wire logic [NCH-1:0] RX_CLK_SRC,
  input wire logic [NCH-1:0] RX_LOS,
  input wire logic [NCH-1:0] RX_NEG_RAIL,
  input wire logic [NCH-1:0] TX_CLK_SRC,
  output logic [NCH-1:0] RX_TERMINATION,
  output logic [NCH-1:0] RX_SIDE_TRISTATE,
  output logic [NCH-1:0] TX_LINE_TRISTATE,
  output logic [NCH-1:0] TX_CLOCK_IN,
  output logic [NCH-1:0] TX_NEG_RAIL_IN
);
  localparam int NP = NCH * lcmfp_pkg::NPORT; // All port pins

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic rst_meta_reg, rst_sync_n; // Two-stage release

  // Assert at once, release after two edges
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      rst_meta_reg <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_n <= rst_meta_reg;
    end
  end

  // ----------------------------------------
  // Pin conditioning
  // ----------------------------------------
  logic [NP-1:0] s1_reg, s2_reg, s3_reg; // Sync stages
  logic [NP-1:0] lvl_reg; // Accepted level per port

  // Three stages; stage one feeds only stage two
  always_ff @(posedge CLK or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      // Pull-up level, so no false low is reported right after reset
      // while the stages refill
      s1_reg <= '1;
      s2_reg <= '1;
      s3_reg <= '1;
    end else begin
      s1_reg <= PORT_IN;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // A level counts once two later stages agree; glitches are dropped
  always_ff @(posedge CLK or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      lvl_reg <= '1;
    end else begin
      for (int i = 0; i < NP; i++) begin
        if (s2_reg[i] == s3_reg[i]) lvl_reg[i] <= s3_reg[i];
      end
    end
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  logic [3:0] rx_a_sel_reg [NCH]; // Receive port a field
  logic [3:0] rx_b_sel_reg [NCH];
  logic [3:0] rx_c_sel_reg [NCH];
  logic [3:0] tx_a_sel_reg [NCH]; // Transmit port a field
  logic [3:0] tx_b_sel_reg [NCH];
  logic [NCH-1:0] rclk_en_reg; // Recovered clock output enable
  logic [NCH-1:0] term_bit_reg; // Termination register bit
  logic [NCH-1:0] tri_bit_reg; // Receive tristate register bit

  // Address split: PADDR[1:0] must be zero
  logic [7:0] a_ch, a_off;
  logic [2:0] chi;
  logic mapped, wr_en;
  logic [31:0] rd_val;
  assign a_ch = PADDR[17:10];
  assign a_off = PADDR[9:2];
  assign chi = a_ch[2:0];

  // Known register offsets inside a channel
  function automatic logic known_off(input logic [7:0] off);
    return off == lcmfp_pkg::OFF_CFG_ONE || off == lcmfp_pkg::OFF_CFG_TWO ||
           off == lcmfp_pkg::OFF_CFG_THREE || off == lcmfp_pkg::OFF_CFG_FIVE ||
           off == lcmfp_pkg::OFF_READBACK || off == lcmfp_pkg::OFF_TERM_CTL ||
           off == lcmfp_pkg::OFF_TRI_CTL;
  endfunction

  // Place a 4-bit field at its bit position, msb on the left
  function automatic logic [31:0] put_sel(input logic [3:0] v, input int lsb);
    return 32'(v) << lsb;
  endfunction

  // Unmapped: channel above seven, unknown offset or misaligned address
  assign mapped = (PADDR[1:0] == 2'h0) && (a_ch <= lcmfp_pkg::CH_MAX) &&
                  (32'(a_ch) < NCH) && known_off(a_off);
  // Write lands only on the completing access edge
  assign wr_en = PSEL && PENABLE && PREADY && PWRITE && PSTRB[0] && mapped;

  // Read mux; reserved bits read zero
  always_comb begin
    rd_val = 32'h0;
    case (a_off)
      lcmfp_pkg::OFF_CFG_ONE: rd_val = put_sel(rx_a_sel_reg[chi], lcmfp_pkg::RXSEL_LSB) |
                                       put_sel(tx_a_sel_reg[chi], lcmfp_pkg::TXSEL_LSB);
      lcmfp_pkg::OFF_CFG_TWO: rd_val = put_sel(rx_b_sel_reg[chi], lcmfp_pkg::RXSEL_LSB) |
                                       put_sel(tx_b_sel_reg[chi], lcmfp_pkg::TXSEL_LSB);
      lcmfp_pkg::OFF_CFG_THREE: rd_val = put_sel(rx_c_sel_reg[chi], lcmfp_pkg::RXSEL_LSB);
      lcmfp_pkg::OFF_CFG_FIVE: rd_val[lcmfp_pkg::RCLK_EN_BIT] = rclk_en_reg[chi];
      lcmfp_pkg::OFF_TERM_CTL: rd_val[lcmfp_pkg::TERM_BIT] = term_bit_reg[chi];
      lcmfp_pkg::OFF_TRI_CTL: rd_val[lcmfp_pkg::TRI_BIT] = tri_bit_reg[chi];
      lcmfp_pkg::OFF_READBACK: rd_val[4:0] = lvl_reg[chi*lcmfp_pkg::NPORT +: 5];
      default: rd_val = 32'h0;
    endcase
  end

  // Field storage; reserved write bits are dropped
  // Only byte lane zero gates writes, since every field sits in it
  always_ff @(posedge CLK or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      for (int c = 0; c < NCH; c++) begin
        rx_a_sel_reg[c] <= lcmfp_pkg::SEL_RST;
        rx_b_sel_reg[c] <= lcmfp_pkg::SEL_RST;
        rx_c_sel_reg[c] <= lcmfp_pkg::RXC_SEL_RST;
        tx_a_sel_reg[c] <= lcmfp_pkg::SEL_RST;
        tx_b_sel_reg[c] <= lcmfp_pkg::SEL_RST;
      end
    end else if (wr_en) begin
      case (a_off)
        lcmfp_pkg::OFF_CFG_ONE: begin
          rx_a_sel_reg[chi] <= PWDATA[lcmfp_pkg::RXSEL_LSB +: lcmfp_pkg::SEL_W];
          tx_a_sel_reg[chi] <= PWDATA[lcmfp_pkg::TXSEL_LSB +: lcmfp_pkg::SEL_W];
        end
        lcmfp_pkg::OFF_CFG_TWO: begin
          rx_b_sel_reg[chi] <= PWDATA[lcmfp_pkg::RXSEL_LSB +: lcmfp_pkg::SEL_W];
          tx_b_sel_reg[chi] <= PWDATA[lcmfp_pkg::TXSEL_LSB +: lcmfp_pkg::SEL_W];
        end
        lcmfp_pkg::OFF_CFG_THREE: begin
          rx_c_sel_reg[chi] <= PWDATA[lcmfp_pkg::RXSEL_LSB +: lcmfp_pkg::SEL_W];
        end
        default: begin
        end
      endcase
    end
  end

  // Single control bits
  always_ff @(posedge CLK or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rclk_en_reg <= {NCH{lcmfp_pkg::RCLK_EN_RST}};
      term_bit_reg <= {NCH{lcmfp_pkg::BIT_RST}};
      tri_bit_reg <= {NCH{lcmfp_pkg::BIT_RST}};
    end else if (wr_en) begin
      if (a_off == lcmfp_pkg::OFF_CFG_FIVE) rclk_en_reg[chi] <= PWDATA[lcmfp_pkg::RCLK_EN_BIT];
      if (a_off == lcmfp_pkg::OFF_TERM_CTL) term_bit_reg[chi] <= PWDATA[lcmfp_pkg::TERM_BIT];
      if (a_off == lcmfp_pkg::OFF_TRI_CTL) tri_bit_reg[chi] <= PWDATA[lcmfp_pkg::TRI_BIT];
    end
  end

  // ----------------------------------------
  // APB answer
  // ----------------------------------------
  // Answer prepared in setup, so access completes in its first cycle
  // Read data holds until the next setup; the error flag only with ready
  always_ff @(posedge CLK or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      PREADY <= 1'b0;
      PRDATA <= 32'h0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= PSEL && !PENABLE;
      if (PSEL && !PENABLE) begin
        PRDATA <= (mapped && !PWRITE) ? rd_val : 32'h0;
        PSLVERR <= !mapped;
      end else begin
        PSLVERR <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Channels
  // ----------------------------------------
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    // Five ports per channel: three receive, two transmit
    lcmfp_chan u_chan (
      .clk(CLK),
      .rst_n(rst_sync_n),
      .sel_rxa(rx_a_sel_reg[c]),
      .sel_rxb(rx_b_sel_reg[c]),
      .sel_rxc(rx_c_sel_reg[c]),
      .sel_txa(tx_a_sel_reg[c]),
      .sel_txb(tx_b_sel_reg[c]),
      .rclk_en(rclk_en_reg[c]),
      .term_bit(term_bit_reg[c]),
      .tri_bit(tri_bit_reg[c]),
      .lvl(lvl_reg[c*lcmfp_pkg::NPORT +: lcmfp_pkg::NPORT]),
      .rclk(RX_CLK_SRC[c]),
      .los(RX_LOS[c]),
      .neg(RX_NEG_RAIL[c]),
      .txclk(TX_CLK_SRC[c]),
      .pin_out(PORT_OUT[c*lcmfp_pkg::NPORT +: lcmfp_pkg::NPORT]),
      .pin_oe_n(PORT_OE_N[c*lcmfp_pkg::NPORT +: lcmfp_pkg::NPORT]),
      .term(RX_TERMINATION[c]),
      .rx_tri(RX_SIDE_TRISTATE[c]),
      .tx_tri(TX_LINE_TRISTATE[c]),
      .tx_clk_in(TX_CLOCK_IN[c]),
      .tx_neg_in(TX_NEG_RAIL_IN[c])
    );
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!rst_sync_n);

  sequence rd_level_setup;
    PSEL && !PENABLE && !PWRITE && PADDR == {8'h00, lcmfp_pkg::OFF_READBACK, 2'h0};
  endsequence
  sequence wr_cfg3_take;
    PSEL && PENABLE && PREADY && PWRITE && PSTRB[0] &&
      PADDR == {8'h00, lcmfp_pkg::OFF_CFG_THREE, 2'h0};
  endsequence
  sequence bad_ch_setup;
    PSEL && !PENABLE && a_ch > lcmfp_pkg::CH_MAX;
  endsequence
  sequence wr_no_strobe;
    PSEL && PENABLE && PREADY && PWRITE && !PSTRB[0] &&
      PADDR == {8'h00, lcmfp_pkg::OFF_CFG_ONE, 2'h0};
  endsequence

  cfg_reset_a: assert property ($rose(rst_sync_n) |->
      rx_a_sel_reg[0] == 4'h0 && tx_b_sel_reg[NCH-1] == 4'h0)
    else $error("port field not reset to input");
  rxc_reset_a: assert property ($rose(rst_sync_n) |->
      rx_c_sel_reg[0] == 4'hf && !rclk_en_reg[0])
    else $error("third port reset value wrong");
  level_track_a: assert property ($stable(PORT_IN)[*4] |=> lvl_reg == $past(PORT_IN))
    else $error("port level not tracked");
  level_read_a: assert property (rd_level_setup |=> PREADY && PRDATA[4:0] == $past(lvl_reg[4:0]))
    else $error("readback wrong");
  cfg_write_a: assert property (wr_cfg3_take |=> rx_c_sel_reg[0] == $past(PWDATA[3:0]))
    else $error("selection write lost");
  bad_channel_a: assert property (bad_ch_setup |=> PREADY && PSLVERR)
    else $error("unmapped channel accepted");

  // Bus answer shape: one-cycle ready, errors carry no data
  ready_pulse_a: assert property (PREADY |=> !PREADY)
    else $error("ready held too long");
  err_no_data_a: assert property (PSLVERR |-> PRDATA == 32'h0)
    else $error("error answer carries data");
  rd_reserved_a: assert property (PREADY |-> PRDATA[31:8] == 24'h0)
    else $error("reserved read bits set");

  // Pins stay passive until configuration has had an edge to act
  pins_idle_a: assert property ($rose(rst_sync_n) |-> &PORT_OE_N)
    else $error("pin driven out of reset");

  // A write without its byte strobe leaves the fields alone
  strb_drop_a: assert property (wr_no_strobe |=>
      $stable(rx_a_sel_reg[0]) && $stable(tx_a_sel_reg[0]))
    else $error("write without strobe landed");
endmodule

/* sim/lcmfp_board.sv */
// Purpose: Board model of the multi-function port pins of all channels
// Assumes: Every pin has a pull-up; the bench may drive any pin itself
// Notes: Two drivers on one pin give an unknown level
`timescale 1ns/1ps
module lcmfp_board (
  input wire logic [39:0] port_out,
  input wire logic [39:0] port_oe_n,
  input wire logic [39:0] ext_en,
  input wire logic [39:0] ext_val,
  output logic [39:0] port_in
);
  // ----------------------------------------
  // Pin resolution
  // ----------------------------------------
  // A released pin floats up, it never keeps the last driven value
  always_comb begin
    for (int i = 0; i < 40; i++) begin
      if (!port_oe_n[i] && ext_en[i]) port_in[i] = 1'bx; // Clash
      else if (!port_oe_n[i]) port_in[i] = port_out[i];
      else if (ext_en[i]) port_in[i] = ext_val[i];
      else port_in[i] = 1'b1;
    end
  end
endmodule

/* sim/lcmfp_tb_top.sv */
// Purpose: Self-checking bench for the port selector
// Assumes: Zero-wait APB slave, pins modelled with pull-ups
// Notes: Channel 3 (pins 15 to 19) carries most scenarios
`timescale 1ns/1ps
module lcmfp_tb_top;
  logic clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [17:0] paddr = 18'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'hf;
  logic pready, pslverr, err;
  logic [39:0] port_in, port_out, port_oe_n, ext_en = 40'h0, ext_val = 40'h0;
  logic [7:0] rclk = 8'h0, los = 8'h0, neg = 8'h0, txsrc = 8'h0;
  logic [7:0] term, rtri, xtri, tcin, tneg;
  int miscompares = 0, total_checks = 0, cyc = 0;
  // ----------------------------------------
  // Clock, design and board
  // ----------------------------------------
  always #2 clk = ~clk;
  lcmfp_top #(.NCH(8)) u_dut (.CLK(clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .PORT_IN(port_in), .PORT_OUT(port_out),
    .PORT_OE_N(port_oe_n), .RX_CLK_SRC(rclk), .RX_LOS(los), .RX_NEG_RAIL(neg),
    .TX_CLK_SRC(txsrc), .RX_TERMINATION(term), .RX_SIDE_TRISTATE(rtri),
    .TX_LINE_TRISTATE(xtri), .TX_CLOCK_IN(tcin), .TX_NEG_RAIL_IN(tneg));
  lcmfp_board u_board (.port_out(port_out), .port_oe_n(port_oe_n), .ext_en(ext_en),
    .ext_val(ext_val), .port_in(port_in));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  // Hang guard; the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      miscompares++;
      stop_test;
    end
  end
  task stop_test;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Request held until pready is seen high at an edge
  task apb(input logic w, input logic [7:0] ch, input logic [7:0] off, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {ch, off, 2'b00};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // If pready never rises, only the bench timeout ends this wait
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] ch, input logic [7:0] off, input logic [31:0] wd);
    apb(1'b1, ch, off, wd);
  endtask
  task rdc(input logic [7:0] ch, input logic [7:0] off, input logic [31:0] exp);
    apb(1'b0, ch, off, 32'h0);
    chk(rd, exp, "read data");
    chk({31'h0, err}, 32'h0, "read error");
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_reset;
    for (int c = 0; c < 8; c += 7) begin
      rdc(c[7:0], lcmfp_pkg::OFF_CFG_ONE, 32'h0);
      rdc(c[7:0], lcmfp_pkg::OFF_CFG_TWO, 32'h0);
      rdc(c[7:0], lcmfp_pkg::OFF_CFG_THREE, 32'hf);
      rdc(c[7:0], lcmfp_pkg::OFF_CFG_FIVE, 32'h0);
      rdc(c[7:0], lcmfp_pkg::OFF_READBACK, 32'h1f);
    end
    chk({31'h0, &port_oe_n}, 32'h1, "idle enables");
    $display("reset test done");
  endtask
  task t_gpo;
    wr(8'h3, lcmfp_pkg::OFF_CFG_ONE, 32'hba);
    wr(8'h3, lcmfp_pkg::OFF_CFG_TWO, 32'hab);
    tick(2);
    chk({28'h0, port_out[19:18], port_out[16:15]}, 32'h9, "fixed levels");
    chk({28'h0, port_oe_n[19:18], port_oe_n[16:15]}, 32'h0, "fixed enables");
    tick(4);
    rdc(8'h3, lcmfp_pkg::OFF_READBACK, 32'h15);
    $display("fixed output test done");
  endtask
  task t_outs;
    wr(8'h3, lcmfp_pkg::OFF_CFG_ONE, 32'h7c);
    wr(8'h3, lcmfp_pkg::OFF_CFG_TWO, 32'h0e);
    wr(8'h3, lcmfp_pkg::OFF_CFG_FIVE, 32'h1);
    for (int v = 0; v < 2; v++) begin
      @(posedge clk);
      los[3] <= v[0];
      neg[3] <= ~v[0];
      rclk[3] <= v[0];
      txsrc[3] <= ~v[0];
      tick(2);
      chk({28'h0, port_out[18:15]}, v ? 32'h5 : 32'ha, "routed outputs");
      chk({28'h0, port_oe_n[18:15]}, 32'h0, "routed enables");
    end
    wr(8'h3, lcmfp_pkg::OFF_TRI_CTL, 32'h1);
    tick(2);
    chk({30'h0, rtri[3], port_oe_n[17]}, 32'h3, "clock tristate");
    wr(8'h3, lcmfp_pkg::OFF_TRI_CTL, 32'h0);
    $display("output function test done");
  endtask
  task t_ins;
    wr(8'h3, lcmfp_pkg::OFF_CFG_THREE, 32'h8);
    wr(8'h3, lcmfp_pkg::OFF_CFG_ONE, 32'h3d);
    wr(8'h3, lcmfp_pkg::OFF_CFG_TWO, 32'hd9);
    wr(8'h3, lcmfp_pkg::OFF_CFG_FIVE, 32'h0);
    // Board drives only once every port is an input, so nothing clashes
    @(posedge clk);
    ext_en[19:15] <= 5'h1f;
    for (int v = 0; v < 2; v++) begin
      @(posedge clk);
      ext_val[19:15] <= {5{v[0]}};
      tick(6);
      chk({28'h0, term[3], rtri[3], tcin[3], tneg[3]}, v ? 32'hf : 32'h0, "inputs");
      chk({27'h0, port_oe_n[19:15]}, 32'h1f, "input enables");
      rdc(8'h3, lcmfp_pkg::OFF_READBACK, v ? 32'h1f : 32'h0);
    end
    @(posedge clk);
    ext_val[19:15] <= 5'h0;
    wr(8'h3, lcmfp_pkg::OFF_TERM_CTL, 32'h1);
    wr(8'h3, lcmfp_pkg::OFF_TRI_CTL, 32'h1);
    tick(6);
    chk({30'h0, term[3], rtri[3]}, 32'h3, "register or");
    wr(8'h3, lcmfp_pkg::OFF_TERM_CTL, 32'h0);
    wr(8'h3, lcmfp_pkg::OFF_TRI_CTL, 32'h0);
    // Transmit tristate, active high then active low
    for (int k = 0; k < 4; k++) begin
      wr(8'h3, lcmfp_pkg::OFF_CFG_ONE, k[1] ? 32'he9 : 32'h89);
      @(posedge clk);
      ext_val[18] <= k[0];
      tick(6);
      chk({31'h0, xtri[3]}, {31'h0, k[1] ^ k[0]}, "tx tristate");
    end
    $display("input function test done");
  endtask
  task t_reserved;
    wr(8'h3, lcmfp_pkg::OFF_CFG_ONE, 32'hc7);
    wr(8'h3, lcmfp_pkg::OFF_CFG_TWO, 32'hf1);
    wr(8'h3, lcmfp_pkg::OFF_CFG_THREE, 32'h0);
    @(posedge clk);
    los <= 8'hff;
    neg <= 8'hff;
    rclk <= 8'hff;
    txsrc <= 8'hff;
    ext_val[19:15] <= 5'h0;
    tick(6);
    chk({27'h0, port_oe_n[19:15]}, 32'h1f, "passive pins");
    chk({27'h0, term[3], rtri[3], xtri[3], tcin[3], tneg[3]}, 32'h0, "no effect");
    rdc(8'h3, lcmfp_pkg::OFF_READBACK, 32'h0);
    $display("reserved code test done");
  endtask
  task t_errs;
    apb(1'b0, 8'h8, lcmfp_pkg::OFF_CFG_ONE, 32'h0);
    chk({31'h0, err}, 32'h1, "channel 8 error");
    chk(rd, 32'h0, "channel 8 data");
    apb(1'b0, 8'h0, 8'h83, 32'h0);
    chk({31'h0, err}, 32'h1, "unknown offset");
    wr(8'h0, lcmfp_pkg::OFF_CFG_ONE, 32'h9a);
    rdc(8'h1, lcmfp_pkg::OFF_CFG_ONE, 32'h0);
    rdc(8'h0, lcmfp_pkg::OFF_CFG_ONE, 32'h9a);
    wr(8'h0, lcmfp_pkg::OFF_CFG_THREE, 32'h9);
    rdc(8'h0, lcmfp_pkg::OFF_CFG_THREE, 32'h9);
    @(posedge clk);
    pstrb <= 4'h0;
    wr(8'h0, lcmfp_pkg::OFF_CFG_ONE, 32'h0);
    @(posedge clk);
    pstrb <= 4'hf;
    rdc(8'h0, lcmfp_pkg::OFF_CFG_ONE, 32'h9a);
    $display("decode test done");
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset;
    t_gpo;
    t_outs;
    t_ins;
    t_reserved;
    t_errs;
    stop_test;
  end
endmodule
